//--- rtl/switch_ctrl_pkg.sv
/*
  Shared constants for the quad switch latch and ready control block.
  Assumes a 40 MHz system clock; times are converted to cycle counts here.
*/
package switch_ctrl_pkg;

  localparam int unsigned CHANNELS        = 4;
  localparam int unsigned CLK_HZ          = 40_000_000;
  // Oscillator that clocks the charge pumps
  localparam int unsigned PUMP_OSC_HZ     = 500_000;
  localparam int unsigned PUMP_HALF_CYC   = CLK_HZ / (2 * PUMP_OSC_HZ);
  // Soft turn-on ramp, in microseconds
  localparam int unsigned RAMP_TIME_US    = 1_000;
  localparam int unsigned RAMP_CYC        = (CLK_HZ / 1_000_000) * RAMP_TIME_US;
  // Longest ready pulse, in milliseconds; longest time rounds down
  localparam int unsigned READY_DELAY_TIME_MS = 6;
  localparam int unsigned READY_DELAY_CYC = (CLK_HZ / 1_000) * READY_DELAY_TIME_MS;
  localparam int unsigned TIMER_W         = 18;
  localparam int unsigned OSC_W           = 8;
  localparam logic [CHANNELS-1:0] LATCH_RESET = 4'h0;

endpackage

//--- rtl/switch_ramp.sv
/*
  One channel's soft turn-on ramp: a counter that stands in for the charge
  pump slowly bringing the switch to full conduction.
  Assumes the enable comes from the channel latch and clk_en from the
  parent's clock enable input, so the ramp counts sys_clk cycles.
*/
`timescale 1ns/10ps
module switch_ramp #(
  parameter int unsigned RAMP_CYC = 40_000,
  parameter int unsigned W        = 18
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic enable,
  output logic      fully_on
);

  logic [W-1:0] ramp_q;

  // Ramp climbs while enabled, collapses at once when the latch drops
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ramp_q   <= '0;
      fully_on <= 1'b0;
    end else if (clk_en) begin
      if (!enable) begin
        ramp_q   <= '0;
        fully_on <= 1'b0;
      end else if (ramp_q >= W'(RAMP_CYC - 1)) begin
        fully_on <= 1'b1;
      end else begin
        ramp_q <= ramp_q + W'(1);
      end
    end
  end

endmodule

//--- rtl/quad_switch_ctrl.sv
/*
  Control logic of a four channel power switch: request latches, soft
  turn-on ramps, shared pump oscillator with power-down, and ready timer.
  Assumes requests and the strobe are synchronous to sys_clk.
*/
`timescale 1ns/10ps
module quad_switch_ctrl
  import switch_ctrl_pkg::*;
#(
  parameter int unsigned READY_CYC = switch_ctrl_pkg::READY_DELAY_CYC,
  parameter int unsigned RAMP_LEN  = switch_ctrl_pkg::RAMP_CYC
) (
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  input  wire logic                          clk_en,
  input  wire logic                          switch_request_1,
  input  wire logic                          switch_request_2,
  input  wire logic                          switch_request_3,
  input  wire logic                          switch_request_4,
  input  wire logic                          load_n,
  output logic [switch_ctrl_pkg::CHANNELS-1:0] switch_enable_q,
  output logic [switch_ctrl_pkg::CHANNELS-1:0] switch_full_q,
  output logic                               pump_clk_q,
  output logic                               osc_power_down_q,
  output logic                               ready_n_q
);
  import switch_ctrl_pkg::*;

  typedef enum logic [0:0] {READY_IDLE, READY_WAIT} ready_state_e;

  logic [CHANNELS-1:0] request;
  logic [CHANNELS-1:0] latch_d;
  logic [CHANNELS-1:0] latch_q;
  logic [CHANNELS-1:0] rise;
  logic [CHANNELS-1:0] full_on;
  logic [1:0]          last_ch_q;
  logic [TIMER_W-1:0]  timer_q;
  logic [OSC_W-1:0]    osc_cnt_q;
  ready_state_e        state_q;

  // Lowest-numbered rising channel chosen when several rise together
  function automatic logic [1:0] first_set(input logic [CHANNELS-1:0] v);
    logic [1:0] idx;
    idx = 2'd0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (v[i]) idx = 2'(i);
    end
    return idx;
  endfunction

  assign request = {switch_request_4, switch_request_3,
                    switch_request_2, switch_request_1};

  // Transparent while strobe low; the last low-cycle value is held
  // after the strobe rises, which is the capture at the rising edge
  always_comb begin
    latch_d = load_n ? latch_q : request;
  end

  assign rise = latch_d & ~latch_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      latch_q <= LATCH_RESET;
    end else if (clk_en) begin
      latch_q <= latch_d;
    end
  end

  // Per-channel ramps; a genvar loop keeps the four identical
  for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
    switch_ramp #(
      .RAMP_CYC (RAMP_LEN),
      .W        (TIMER_W)
    ) u_ramp (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .clk_en   (clk_en),
      .enable   (latch_q[g]),
      .fully_on (full_on[g])
    );
  end

  // Registered copies so every output comes from a flop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      switch_enable_q <= '0;
      switch_full_q   <= '0;
    end else if (clk_en) begin
      switch_enable_q <= latch_d;
      switch_full_q   <= full_on;
    end
  end

  // Shared pump oscillator, stopped and parked low when idle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      osc_cnt_q        <= '0;
      pump_clk_q       <= 1'b0;
      osc_power_down_q <= 1'b1;
    end else if (clk_en) begin
      osc_power_down_q <= ~|latch_d;
      if (~|latch_d) begin
        osc_cnt_q  <= '0;
        pump_clk_q <= 1'b0;
      end else if (osc_cnt_q >= OSC_W'(PUMP_HALF_CYC - 1)) begin
        osc_cnt_q  <= '0;
        pump_clk_q <= ~pump_clk_q;
      end else begin
        osc_cnt_q <= osc_cnt_q + OSC_W'(1);
      end
    end
  end

  // Ready timer: a rise restarts it; it ends when the last-risen channel
  // is fully on, or at the ceiling, whichever comes first. The ceiling
  // guards against a channel dropped mid-ramp holding ready low forever.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q   <= READY_IDLE;
      timer_q   <= '0;
      last_ch_q <= 2'd0;
      ready_n_q <= 1'b1;
    end else if (clk_en) begin
      if (|rise) begin
        state_q   <= READY_WAIT;
        timer_q   <= '0;
        last_ch_q <= first_set(rise);
        ready_n_q <= 1'b0;
      end else begin
        case (state_q)
          READY_IDLE: begin
            ready_n_q <= 1'b1;
          end
          READY_WAIT: begin
            if (full_on[last_ch_q] || timer_q >= TIMER_W'(READY_CYC - 2)) begin
              state_q   <= READY_IDLE;
              ready_n_q <= 1'b1;
            end else begin
              timer_q <= timer_q + TIMER_W'(1);
            end
          end
          default: begin
            state_q   <= READY_IDLE;
            ready_n_q <= 1'b1;
          end
        endcase
      end
    end
  end

  AST_HOLD_WHILE_STROBE_HIGH:
  assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && load_n) |=> (latch_q == $past(latch_q)))
    else $error("latch changed while strobe high");

  AST_PASS_WHILE_STROBE_LOW:
  assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && !load_n) |=> (latch_q == $past(request)))
    else $error("latch did not follow request");

  AST_READY_DROPS_ON_RISE:
  assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && |rise) |=> !ready_n_q)
    else $error("ready not low after rise");

  AST_POWER_DOWN_IDLE:
  assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && latch_d == '0) |=> osc_power_down_q)
    else $error("power down missing with all latches low");

  AST_POWER_UP_ACTIVE:
  assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && latch_d != '0) |=> !osc_power_down_q)
    else $error("power down held with a latch high");

  AST_READY_END_NEEDS_FULL:
  assert property (@(posedge sys_clk) disable iff (reset)
    ($rose(ready_n_q) && $past(state_q) == READY_WAIT && $past(timer_q) < TIMER_W'(READY_CYC - 2))
      |-> $past(full_on[last_ch_q]))
    else $error("ready rose before switch fully on");

  AST_READY_BOUNDED:
  assert property (@(posedge sys_clk) disable iff (reset)
    (timer_q <= TIMER_W'(READY_CYC - 1)))
    else $error("ready pulse exceeded its ceiling");

  AST_OSC_STOPPED:
  assert property (@(posedge sys_clk) disable iff (reset)
    osc_power_down_q |-> !pump_clk_q)
    else $error("pump clock runs while powered down");

  AST_ENABLE_MATCHES_LATCH:
  assert property (@(posedge sys_clk) disable iff (reset)
    clk_en |=> (switch_enable_q == latch_q))
    else $error("switch enable differs from latch");

  AST_READY_LOW_IFF_WAITING:
  assert property (@(posedge sys_clk) disable iff (reset)
    ready_n_q == (state_q == READY_IDLE))
    else $error("ready level disagrees with timer state");

  AST_TRACKED_CHANNEL_HIGH:
  assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && |rise) |=> latch_q[last_ch_q])
    else $error("tracked channel is not the one that rose");

  AST_PUMP_HALF_PERIOD:
  assert property (@(posedge sys_clk) disable iff (reset)
    ($changed(pump_clk_q) && !osc_power_down_q)
      |-> ($past(osc_cnt_q) == OSC_W'(PUMP_HALF_CYC - 1)))
    else $error("pump clock toggled off its half period");

endmodule

//--- tb/switch_host_model.sv
/*
  Host side model: drives the four channel requests and the latch strobe.
  Assumes the bench calls load() and that inputs move 1 ns after an edge.
*/
`timescale 1ns/10ps
module switch_host_model (
  input  wire logic       sys_clk,
  output logic      [3:0] req,
  output logic            load_n
);
  // Idle: latch closed, nothing requested
  initial begin
    req    = 4'h0;
    load_n = 1'b1;
  end
  // Open the latch one cycle, close it with requests held across the edge
  task automatic load(input logic [3:0] v);
    @(posedge sys_clk) #1;
    req    = v;
    load_n = 1'b0;
    @(posedge sys_clk) #1;
    load_n = 1'b1;
    @(posedge sys_clk) #1;
    req    = ~v; // Toggled inputs while held prove the hold
  endtask
endmodule

//--- tb/test_quad_switch_ctrl.sv
/*
  Bench for quad_switch_ctrl: channel loads, ready pulse, pump power-down.
  Assumes the host model drives requests; ramp and ready counts shortened.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_quad_switch_ctrl;
  import switch_ctrl_pkg::*;
  localparam int unsigned RDY = 200;
  localparam int unsigned RMP = 50;
  logic                sys_clk = 1'b0;
  logic                reset   = 1'b1;
  logic                clk_en  = 1'b1;
  logic          [3:0] req;
  logic                load_n;
  logic [CHANNELS-1:0] enable;
  logic [CHANNELS-1:0] full;
  logic                pump_clk;
  logic                power_down;
  logic                ready_n;
  int                  bad_count   = 0;
  int                  check_count = 0;
  int                  n;

  always #12.5 sys_clk = ~sys_clk;

  switch_host_model i_host (.sys_clk(sys_clk), .req(req), .load_n(load_n));

  quad_switch_ctrl #(.READY_CYC(RDY), .RAMP_LEN(RMP)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .switch_request_1(req[0]), .switch_request_2(req[1]),
    .switch_request_3(req[2]), .switch_request_4(req[3]), .load_n(load_n),
    .switch_enable_q(enable), .switch_full_q(full), .pump_clk_q(pump_clk),
    .osc_power_down_q(power_down), .ready_n_q(ready_n));

  // Verdict; a timeout lands here as well
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Bounded wait for ready to return high
  task automatic wait_ready(output int c);
    c = 0;
    while (ready_n !== 1'b1) begin
      @(posedge sys_clk) #1;
      c++;
      if (c > RDY) begin
        bad_count++;
        $display("[ERR] ready wait exp 1 got %b", ready_n);
        close_out();
      end
    end
  endtask

  // Pump edges seen over 100 cycles
  task automatic count_pump(output int c);
    logic last;
    c = 0;
    repeat (100) begin
      last = pump_clk;
      @(posedge sys_clk) #1;
      if (pump_clk !== last) c++;
    end
  endtask

  task automatic t_reset();
    `CHK("enable", 4'h0, enable)
    `CHK("full", 4'h0, full)
    `CHK("power_down", 1'b1, power_down)
    `CHK("ready_n", 1'b1, ready_n)
  endtask

  // Each channel alone, from all off
  task automatic t_channels();
    for (int i = 0; i < 4; i++) begin
      i_host.load(4'h0);
      `CHK("power_down", 1'b1, power_down)
      count_pump(n);
      `CHK("pump idle", 0, n)
      i_host.load(4'h1 << i);
      `CHK("enable", 4'h1 << i, enable)
      `CHK("ready_n", 1'b0, ready_n)
      `CHK("power_down", 1'b0, power_down)
      wait_ready(n);
      `CHK("ready length", 1'b1, n >= RMP - 1 && n < RDY)
      `CHK("full", 1'b1, full[i])
      if (i == 0) begin
        count_pump(n);
        `CHK("pump edges", 1'b1, n >= 2 && n <= 3)
      end
    end
  endtask

  // Second rise mid-pulse restarts and retargets the timer
  task automatic t_restart();
    i_host.load(4'h0);
    i_host.load(4'h1);
    repeat (10) @(posedge sys_clk) #1;
    i_host.load(4'h3);
    `CHK("ready_n", 1'b0, ready_n)
    wait_ready(n);
    `CHK("full", 4'h3, full)
    `CHK("restart", 1'b1, n >= RMP - 1)
  endtask

  // Clock enable low freezes capture, ramp and ready timer
  task automatic t_freeze();
    i_host.load(4'h0);
    clk_en = 1'b0;
    i_host.load(4'h8);
    `CHK("frozen enable", 4'h0, enable)
    `CHK("frozen power_down", 1'b1, power_down)
    clk_en = 1'b1;
    i_host.load(4'h8);
    clk_en = 1'b0;
    repeat (RMP + 10) @(posedge sys_clk) #1;
    `CHK("frozen ready_n", 1'b0, ready_n)
    `CHK("frozen full", 4'h0, full)
    clk_en = 1'b1;
    wait_ready(n);
    `CHK("full after freeze", 4'h8, full)
  endtask

  initial begin
    repeat (2) @(posedge sys_clk) #1;
    reset = 1'b0;
    t_reset();
    t_channels();
    t_restart();
    t_freeze();
    close_out();
  end
endmodule
